// *** rtl/mixer_top.sv ***
// Top of the two-pair complex mixer and IQ correction datapath with AXI4-Lite registers.
// Assumes samples arrive every clock from the interpolator and leave to the converter cores.
//
// Design decisions made here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
// Behaviour
// [RULE_01] Two independent pair paths, each with its own oscillator and coarse mixer.
// [RULE_02] Oscillator uses 32-bit frequency and 16-bit phase words to make sine/cosine.
// [RULE_03] Sync event, chosen by 4-bit selector, clears both phase accumulators.
// [RULE_04] Frequency word added to accumulator every sample clock.
// [RULE_05] Phase offset word added to oscillator phase, full turn is 2^16.
// [RULE_06] Multiplier gives I cos minus Q sin, I sin plus Q cos, scaled.
// [RULE_07] Gain bit one is full scale, zero halves multiplier output.
// [RULE_08] Coarse mode off passes samples unchanged.
// [RULE_09] Fs/2 mode negates every second sample of I and Q.
// [RULE_10] Plus fs/4 mode applies rotating negate and swap sequence.
// [RULE_11] Minus fs/4 mode applies opposite rotating negate and swap sequence.
// [RULE_12] Negate/swap modes bypass multiplier so gain bit has no effect.
// [RULE_13] Coarse field bits enable fs/8, fs/4, fs/2 and minus fs/4.
// [RULE_14] Combined codes give plus/minus fs/8 and 3fs/8 shifts.
// [RULE_15] Fs/8 mixing uses multiplier with fixed terms, gain bit applies.
// [RULE_16] Only normal and fs/2 keep channel data separate.
// [RULE_17] Per-channel 11-bit unsigned gain, one integer bit, resets to one.
// [RULE_18] Per-pair 12-bit phase constant times Q is added into I.
// [RULE_19] Each channel adds its own 13-bit signed DC offset.
// [RULE_20] Offset and data add with their LSBs aligned.
// [RULE_21] Each channel has its own 8-bit delay trim word.
// [RULE_22] Software should take care with full mixer gain, output may clip.
// [RULE_23] Correction arithmetic saturates to 16-bit signed range.
// [RULE_24] Order is mixing, gain/phase, offset, then delay trim.
module mixer_top import mixer_pkg::*; (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [3:0] SYNC_SRC,
  input wire iq_t DIN_PAIR0,
  input wire iq_t DIN_PAIR1,
  output iq_t DOUT_PAIR0,
  output iq_t DOUT_PAIR1,
  output logic [31:0] DELAY_TRIM,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  logic [31:0] freq_word_pair0;
  logic [31:0] freq_word_pair1;
  logic [15:0] phase_ofs_pair0;
  logic [15:0] phase_ofs_pair1;
  logic [31:0] mode;
  logic [21:0] iq_gain_pair0;
  logic [21:0] iq_gain_pair1;
  logic [23:0] iq_phase_const;
  logic [12:0] dc_offset_ch0;
  logic [12:0] dc_offset_ch1;
  logic [12:0] dc_offset_ch2;
  logic [12:0] dc_offset_ch3;
  logic [31:0] delay_trim;
  logic [3:0] osc_sync_select;
  logic sw_sync;
  logic osc_sync;
  logic [15:0] sync_count;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic next_bvalid;
  iq_t path0_out;
  iq_t path1_out;
  iq_t hist [4][4];
  logic [31:0] reg_rd;
  logic rd_hit;

  assign osc_sync_select = mode[POS_SYNC_SEL +: 4];

  // Sync source: 0 none, 1-4 external lines, 15 software pulse
  always_comb begin
    case (osc_sync_select)
      4'd1: osc_sync = SYNC_SRC[0];
      4'd2: osc_sync = SYNC_SRC[1];
      4'd3: osc_sync = SYNC_SRC[2];
      4'd4: osc_sync = SYNC_SRC[3];
      4'd15: osc_sync = sw_sync;
      default: osc_sync = 1'b0;
    endcase
  end // [RULE_03]

  // Pair 0 datapath
  iq_path u_pair0 (
    .clk(CLK),
    .rst(RST),
    .sync(osc_sync),
    .din(DIN_PAIR0),
    .cmix(mode[POS_CMIX0 +: 4]),
    .fine_en(mode[POS_FINE_EN]),
    .mix_gain(mode[POS_MIX_GAIN]),
    .freq_word(freq_word_pair0),
    .phase_ofs(phase_ofs_pair0),
    .gain_i(iq_gain_pair0[10:0]),
    .gain_q(iq_gain_pair0[21:11]),
    .iq_phase(iq_phase_const[11:0]),
    .ofs_i(dc_offset_ch0),
    .ofs_q(dc_offset_ch1),
    .dout(path0_out)
  ); // [RULE_01]

  // Pair 1 datapath
  iq_path u_pair1 (
    .clk(CLK),
    .rst(RST),
    .sync(osc_sync),
    .din(DIN_PAIR1),
    .cmix(mode[POS_CMIX1 +: 4]),
    .fine_en(mode[POS_FINE_EN + 1]),
    .mix_gain(mode[POS_MIX_GAIN + 1]),
    .freq_word(freq_word_pair1),
    .phase_ofs(phase_ofs_pair1),
    .gain_i(iq_gain_pair1[10:0]),
    .gain_q(iq_gain_pair1[21:11]),
    .iq_phase(iq_phase_const[23:12]),
    .ofs_i(dc_offset_ch2),
    .ofs_q(dc_offset_ch3),
    .dout(path1_out)
  );

  // Per-channel delay line; trim low two bits pick 0-3 whole samples
  always_ff @(posedge CLK) begin
    if (RST) begin
      for (int c = 0; c < 4; c++) begin
        for (int k = 0; k < 4; k++) begin
          hist[c][k] <= '0;
        end
      end
    end else begin
      hist[0][0].i <= path0_out.i;
      hist[1][0].i <= path0_out.q;
      hist[2][0].i <= path1_out.i;
      hist[3][0].i <= path1_out.q;
      for (int c = 0; c < 4; c++) begin
        hist[c][0].q <= '0;
        for (int k = 1; k < 4; k++) begin
          hist[c][k] <= hist[c][k-1];
        end
      end
    end
  end

  // Output sample per channel selected by its trim word
  always_ff @(posedge CLK) begin
    if (RST) begin
      DOUT_PAIR0 <= '0;
      DOUT_PAIR1 <= '0;
      DELAY_TRIM <= '0;
    end else begin
      DOUT_PAIR0.i <= hist[0][delay_trim[1:0]].i; // [RULE_21]
      DOUT_PAIR0.q <= hist[1][delay_trim[9:8]].i;
      DOUT_PAIR1.i <= hist[2][delay_trim[17:16]].i;
      DOUT_PAIR1.q <= hist[3][delay_trim[25:24]].i; // [RULE_24]
      DELAY_TRIM <= delay_trim;
    end
  end

  // Count sync events for status readback
  always_ff @(posedge CLK) begin
    if (RST) begin
      sync_count <= 16'h0;
    end else if (osc_sync) begin
      sync_count <= sync_count + 16'h1;
    end
  end

  // Write address and data capture, either order
  always_ff @(posedge CLK) begin
    if (RST) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  assign do_write = aw_held && w_held && !S_AXI_BVALID;
  assign next_bvalid = do_write || (S_AXI_BVALID && !S_AXI_BREADY);

  // Ready and response handshake
  always_ff @(posedge CLK) begin
    if (RST) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
    end else begin
      S_AXI_AWREADY <= !aw_held && !(S_AXI_AWVALID && S_AXI_AWREADY);
      S_AXI_WREADY <= !w_held && !(S_AXI_WVALID && S_AXI_WREADY);
      S_AXI_BVALID <= next_bvalid;
      if (do_write) begin
        S_AXI_BRESP <= (aw_addr[7:2] <= OFS_DELAY[7:2] && aw_addr[1:0] == 2'b00) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Register file, whole-word writes with byte strobes ignored; software sync pulse is self-clearing
  always_ff @(posedge CLK) begin
    if (RST) begin
      freq_word_pair0 <= 32'h0;
      freq_word_pair1 <= 32'h0;
      phase_ofs_pair0 <= 16'h0;
      phase_ofs_pair1 <= 16'h0;
      mode <= MODE_RESET;
      iq_gain_pair0 <= {GAIN_UNITY, GAIN_UNITY}; // [RULE_17]
      iq_gain_pair1 <= {GAIN_UNITY, GAIN_UNITY};
      iq_phase_const <= 24'h0;
      dc_offset_ch0 <= 13'h0;
      dc_offset_ch1 <= 13'h0;
      dc_offset_ch2 <= 13'h0;
      dc_offset_ch3 <= 13'h0;
      delay_trim <= 32'h0;
      sw_sync <= 1'b0;
    end else begin
      sw_sync <= 1'b0;
      if (do_write) begin
        case (aw_addr)
          OFS_FREQ0: freq_word_pair0 <= w_data; // [RULE_02]
          OFS_FREQ1: freq_word_pair1 <= w_data;
          OFS_PHASE: begin
            phase_ofs_pair0 <= w_data[15:0];
            phase_ofs_pair1 <= w_data[31:16];
          end
          OFS_MODE: begin
            mode <= {15'h0, w_data[16:0]} & 32'h0000ffff;
            sw_sync <= w_data[POS_SW_SYNC];
          end
          OFS_GAIN0: iq_gain_pair0 <= w_data[21:0];
          OFS_GAIN1: iq_gain_pair1 <= w_data[21:0];
          OFS_IQPH: iq_phase_const <= w_data[23:0];
          OFS_DCOF0: dc_offset_ch0 <= w_data[12:0];
          OFS_DCOF1: dc_offset_ch1 <= w_data[12:0];
          OFS_DCOF2: dc_offset_ch2 <= w_data[12:0];
          OFS_DCOF3: dc_offset_ch3 <= w_data[12:0];
          OFS_DELAY: delay_trim <= w_data; // [RULE_21]
          default: ;
        endcase
      end
    end
  end

  // Read mux
  always_comb begin
    rd_hit = 1'b1;
    case (S_AXI_ARADDR)
      OFS_FREQ0: reg_rd = freq_word_pair0;
      OFS_FREQ1: reg_rd = freq_word_pair1;
      OFS_PHASE: reg_rd = {phase_ofs_pair1, phase_ofs_pair0};
      OFS_MODE: reg_rd = mode;
      OFS_GAIN0: reg_rd = {10'h0, iq_gain_pair0};
      OFS_GAIN1: reg_rd = {10'h0, iq_gain_pair1};
      OFS_IQPH: reg_rd = {8'h0, iq_phase_const};
      OFS_DCOF0: reg_rd = {19'h0, dc_offset_ch0};
      OFS_DCOF1: reg_rd = {19'h0, dc_offset_ch1};
      OFS_DCOF2: reg_rd = {19'h0, dc_offset_ch2};
      OFS_DCOF3: reg_rd = {19'h0, dc_offset_ch3};
      OFS_DELAY: reg_rd = delay_trim;
      OFS_STATUS: reg_rd = {16'h0, sync_count};
      default: begin
        reg_rd = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Read channel, one read outstanding
  always_ff @(posedge CLK) begin
    if (RST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0;
      S_AXI_RRESP <= RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= !S_AXI_RVALID && !(S_AXI_ARVALID && S_AXI_ARREADY);
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= reg_rd;
        S_AXI_RRESP <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end
endmodule

// *** rtl/mixer_pkg.sv ***
// Shared constants, register map and sample carriers for the mixer/IQ correction block.
// Assumes a single 40 MHz clock domain and an AXI4-Lite register port.
package mixer_pkg;
  localparam int DW = 16;
  // Register byte offsets
  localparam logic [7:0] OFS_FREQ0 = 8'h00;
  localparam logic [7:0] OFS_FREQ1 = 8'h04;
  localparam logic [7:0] OFS_PHASE = 8'h08;
  localparam logic [7:0] OFS_MODE = 8'h0c;
  localparam logic [7:0] OFS_GAIN0 = 8'h10;
  localparam logic [7:0] OFS_GAIN1 = 8'h14;
  localparam logic [7:0] OFS_IQPH = 8'h18;
  localparam logic [7:0] OFS_DCOF0 = 8'h1c;
  localparam logic [7:0] OFS_DCOF1 = 8'h20;
  localparam logic [7:0] OFS_DCOF2 = 8'h24;
  localparam logic [7:0] OFS_DCOF3 = 8'h28;
  localparam logic [7:0] OFS_DELAY = 8'h2c;
  localparam logic [7:0] OFS_STATUS = 8'h30;
  // Mode register field positions
  localparam int POS_CMIX0 = 0;
  localparam int POS_CMIX1 = 4;
  localparam int POS_FINE_EN = 8;
  localparam int POS_MIX_GAIN = 10;
  localparam int POS_SYNC_SEL = 12;
  localparam int POS_SW_SYNC = 16;
  // Reset values
  localparam logic [10:0] GAIN_UNITY = 11'h400;
  localparam logic [31:0] MODE_RESET = 32'h00000400;
  // Fixed fs/8 sine/cosine magnitude, 0.7071 in Q1.15
  localparam logic signed [17:0] COS45 = 18'sh05a82;
  localparam logic signed [17:0] ONE_Q15 = 18'sh08000;
  localparam int NCO_LUT = 64;
  typedef struct packed {
    logic signed [DW-1:0] i;
    logic signed [DW-1:0] q;
  } iq_t;
  typedef enum logic [1:0] {RESP_OKAY = 2'b00, RESP_SLVERR = 2'b10} resp_t;
  typedef enum {WR_IDLE, WR_RESP} wr_state_t;
endpackage

// *** rtl/nco_osc.sv ***
// Numerically controlled oscillator for one mixing path.
// Assumes synchronous active-high reset; sync is a one-cycle pulse.
`timescale 1ns/10ps
module nco_osc import mixer_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic sync,
  input wire logic [31:0] freq_word,
  input wire logic [15:0] phase_ofs,
  output logic signed [17:0] cos_term,
  output logic signed [17:0] sin_term
);
  logic [31:0] acc;
  logic [15:0] phase;
  logic signed [17:0] sin_lut [NCO_LUT];
  logic [7:0] idx;
  logic [5:0] fine;
  logic signed [17:0] s_val;
  logic signed [17:0] c_val;

  // Quarter-wave sine table, 64 points, Q1.15
  generate
    for (genvar k = 0; k < NCO_LUT; k++) begin : g_lut
      assign sin_lut[k] = 18'($rtoi(32767.0 * $sin(3.14159265358979 * (k + 0.5) / 128.0)));
    end
  endgenerate

  // Accumulator advances each clock, cleared by sync
  always_ff @(posedge clk) begin
    if (rst || sync) begin
      acc <= 32'h0; // [RULE_03]
    end else begin
      acc <= acc + freq_word; // [RULE_04]
    end
  end

  // Phase with offset added
  assign phase = acc[31:16] + phase_ofs; // [RULE_05]
  assign idx = phase[15:8];
  assign fine = idx[6] ? ~idx[5:0] : idx[5:0];

  // Quadrant folding of the sine table
  always_comb begin
    s_val = sin_lut[fine];
    c_val = sin_lut[~fine];
    case (idx[7:6])
      2'd0: begin cos_term = c_val; sin_term = s_val; end
      2'd1: begin cos_term = -c_val; sin_term = s_val; end
      2'd2: begin cos_term = -c_val; sin_term = -s_val; end
      default: begin cos_term = c_val; sin_term = -s_val; end
    endcase
  end // [RULE_02]
endmodule

// *** rtl/iq_path.sv ***
// One complex channel pair: coarse/fine mixing then gain, phase and offset correction.
// Assumes one sample per clock and registers written from the bus slave.
`timescale 1ns/10ps
module iq_path import mixer_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic sync,
  input wire iq_t din,
  input wire logic [3:0] cmix,
  input wire logic fine_en,
  input wire logic mix_gain,
  input wire logic [31:0] freq_word,
  input wire logic [15:0] phase_ofs,
  input wire logic [10:0] gain_i,
  input wire logic [10:0] gain_q,
  input wire logic [11:0] iq_phase,
  input wire logic [12:0] ofs_i,
  input wire logic [12:0] ofs_q,
  output iq_t dout
);
  logic [1:0] seq;
  logic [2:0] seq8;
  iq_t coarse;
  logic signed [17:0] c_nco;
  logic signed [17:0] s_nco;
  logic signed [17:0] c_m;
  logic signed [17:0] s_m;
  logic signed [35:0] mi;
  logic signed [35:0] mq;
  iq_t mixed;
  iq_t mix_q;
  logic signed [31:0] gi;
  logic signed [31:0] gq;
  logic signed [31:0] ph;
  logic signed [31:0] ci;
  logic signed [31:0] cq;

  function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
    if (v > 32'sd32767) sat16 = 16'sh7fff;
    else if (v < -32'sd32768) sat16 = 16'sh8000;
    else sat16 = v[15:0];
  endfunction // [RULE_23]

  // Fine oscillator of this pair
  nco_osc u_nco (
    .clk(clk),
    .rst(rst),
    .sync(sync),
    .freq_word(freq_word),
    .phase_ofs(phase_ofs),
    .cos_term(c_nco),
    .sin_term(s_nco)
  ); // [RULE_01]

  // Sample position counters for coarse modes
  always_ff @(posedge clk) begin
    if (rst || sync) begin
      seq <= 2'd0;
      seq8 <= 3'd0;
    end else begin
      seq <= seq + 2'd1;
      seq8 <= seq8 + 3'd1;
    end
  end

  // Negate/swap coarse mixing, no multiplier
  always_comb begin
    coarse = din; // [RULE_08]
    case (cmix[2:0])
      3'b010: begin
        if (seq[0]) begin coarse.i = -din.i; coarse.q = -din.q; end // [RULE_09]
      end
      3'b100: begin
        case (seq)
          2'd1: begin coarse.i = -din.q; coarse.q = din.i; end
          2'd2: begin coarse.i = -din.i; coarse.q = -din.q; end
          2'd3: begin coarse.i = din.q; coarse.q = -din.i; end
          default: coarse = din;
        endcase // [RULE_10]
      end
      // Fs/4 together with fs/2 folds to the minus fs/4 sequence
      3'b001, 3'b110: begin // [RULE_14]
        case (seq)
          2'd1: begin coarse.i = din.q; coarse.q = -din.i; end
          2'd2: begin coarse.i = -din.i; coarse.q = -din.q; end
          2'd3: begin coarse.i = -din.q; coarse.q = din.i; end
          default: coarse = din;
        endcase // [RULE_11]
      end
      default: coarse = din;
    endcase
  end // [RULE_12] [RULE_13]

  // Fixed fs/8 terms or fine oscillator feed the multiplier
  always_comb begin
    c_m = ONE_Q15;
    s_m = 18'sh0;
    if (cmix[3]) begin
      case (seq8)
        3'd0: begin c_m = ONE_Q15; s_m = 18'sh0; end
        3'd1: begin c_m = COS45; s_m = COS45; end
        3'd2: begin c_m = 18'sh0; s_m = ONE_Q15; end
        3'd3: begin c_m = -COS45; s_m = COS45; end
        3'd4: begin c_m = -ONE_Q15; s_m = 18'sh0; end
        3'd5: begin c_m = -COS45; s_m = -COS45; end
        3'd6: begin c_m = 18'sh0; s_m = -ONE_Q15; end
        default: begin c_m = COS45; s_m = -COS45; end
      endcase // [RULE_15]
    end else if (fine_en) begin
      c_m = c_nco;
      s_m = s_nco;
    end
  end

  // Complex multiply with 2^(gain-1) scale
  assign mi = coarse.i * c_m - coarse.q * s_m; // [RULE_06]
  assign mq = coarse.i * s_m + coarse.q * c_m;
  always_comb begin
    mixed = coarse;
    if (cmix[3] || fine_en) begin
      if (mix_gain) begin
        mixed.i = sat16(32'(mi >>> 15));
        mixed.q = sat16(32'(mq >>> 15));
      end else begin
        mixed.i = sat16(32'(mi >>> 16));
        mixed.q = sat16(32'(mq >>> 16));
      end // [RULE_07]
    end
  end // [RULE_16]

  // Pipeline stage after mixing
  always_ff @(posedge clk) begin
    if (rst) begin
      mix_q <= '0;
    end else begin
      mix_q <= mixed;
    end
  end

  // Gain Q1.10, phase constant scaled by 2^-12 from Q into I, offset LSB aligned
  assign gi = 32'(mix_q.i * $signed({1'b0, gain_i})) >>> 10; // [RULE_17]
  assign gq = 32'(mix_q.q * $signed({1'b0, gain_q})) >>> 10;
  assign ph = 32'(mix_q.q * $signed(iq_phase)) >>> 12; // [RULE_18]
  assign ci = gi + ph + 32'($signed(ofs_i)); // [RULE_19] [RULE_20]
  assign cq = gq + 32'($signed(ofs_q));

  // Corrected output register
  always_ff @(posedge clk) begin
    if (rst) begin
      dout <= '0;
    end else begin
      dout.i <= sat16(ci); // [RULE_24]
      dout.q <= sat16(cq);
    end
  end
endmodule

// *** test/mixer_top_properties.sv ***
// Checker on the register port of the mixer top.
// Assumes it is bound to mixer_top and sees only its ports.
`timescale 1ns/10ps
module mixer_top_chk (
  input wire logic CLK,
  input wire logic RST,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // Answers stand until taken
  chk_bvalid_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write answer dropped early");
  chk_rvalid_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read answer dropped early");
  // Answer timing
  chk_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read answer late");
  chk_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
    |-> ##[1:3] S_AXI_BVALID) else $error("write answer late");
  // Response codes
  chk_unmapped_read: assert property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR > 8'h30
    |=> S_AXI_RRESP == 2'b10 && S_AXI_RDATA == 32'h0) else $error("unmapped read not refused");
  chk_mapped_read: assert property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR <= 8'h30
    && S_AXI_ARADDR[1:0] == 2'b00 |=> S_AXI_RRESP == 2'b00) else $error("mapped read refused");
  chk_resp_code: assert property (S_AXI_BVALID |-> S_AXI_BRESP == 2'b00 || S_AXI_BRESP == 2'b10)
    else $error("illegal write response");
  // One write at a time
  chk_aw_busy: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY)
    else $error("address taken while answer pending");
  // Quiet port right after reset
  chk_reset_quiet: assert property (disable iff (1'b0) RST |=> !S_AXI_AWREADY && !S_AXI_ARREADY
    && !S_AXI_BVALID && !S_AXI_RVALID) else $error("port active in reset");
  cov_write: cover property (S_AXI_BVALID && S_AXI_BREADY);
  cov_read: cover property (S_AXI_RVALID && S_AXI_RREADY);
  cov_refused: cover property (S_AXI_RVALID && S_AXI_RRESP == 2'b10);
endmodule
bind mixer_top mixer_top_chk mixer_top_chk_i (.CLK(CLK), .RST(RST), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY));

// *** test/sample_feed.sv ***
// Upstream interpolator model: launches one sample per pair each clock.
// Assumes the bench sets the values to send; zero while in reset.
`timescale 1ns/10ps
module sample_feed import mixer_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire iq_t set0,
  input wire iq_t set1,
  output iq_t din0,
  output iq_t din1
);
  // Registered launch, like the filter chain output stage
  always_ff @(posedge clk) begin
    if (rst) begin
      din0 <= '0;
      din1 <= '0;
    end else begin
      din0 <= set0;
      din1 <= set1;
    end
  end
endmodule

// *** test/tb_mixer_top.sv ***
// Bench for the mixer top: AXI4-Lite register tasks and sample sequences.
// Assumes the sample feed model in front and the bound port checker.
`timescale 1ns/10ps
module tb_mixer_top import mixer_pkg::*; ;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic [3:0] sync_src = 4'h0;
  iq_t set0, set1, din0, din1, dout0, dout1, p;
  iq_t h [12];
  logic [31:0] trim, wdata, rdata, v;
  logic [7:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  int miscompares = 0;
  int checks = 0;
  int cyc = 0;
  logic [3:0] codes [8] = '{4'h0, 4'h2, 4'h4, 4'h1, 4'h8, 4'ha, 4'hc, 4'he};
  always #12.5 CLK = ~CLK;
  sample_feed sample_feed_i (.clk(CLK), .rst(RST), .set0(set0), .set1(set1), .din0(din0), .din1(din1));
  mixer_top mixer_top_i (.CLK(CLK), .RST(RST), .SYNC_SRC(sync_src), .DIN_PAIR0(din0), .DIN_PAIR1(din1),
    .DOUT_PAIR0(dout0), .DOUT_PAIR1(dout1), .DELAY_TRIM(trim), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
  task tally_and_finish;
    if (miscompares == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Cut a hang short
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      tally_and_finish;
    end
  end
  task cmp32(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task cmp16(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // Write: address and data offered together, each released when taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic done;
    done = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge CLK);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        resp = bresp;
        done = 1'b1;
      end
    end
  endtask
  task rd(input logic [7:0] a);
    logic done;
    done = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge CLK);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        v = rdata;
        resp = rresp;
        done = 1'b1;
      end
    end
  endtask
  task rec(input int n);
    for (int j = 0; j < n; j++) begin
      @(posedge CLK);
      h[j] = dout0;
    end
  endtask
  task pulse;
    sync_src <= 4'h1;
    @(posedge CLK);
    sync_src <= 4'h0;
    repeat (6) @(posedge CLK);
  endtask
  // Next output of a negate/swap mode from the one before
  function automatic iq_t rot(input logic [3:0] c, input iq_t x);
    case (c)
      4'h2: rot = '{-x.i, -x.q};
      4'h4: rot = '{-x.q, x.i};
      4'h1: rot = '{x.q, -x.i};
      default: rot = x;
    endcase
  endfunction
  initial begin
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    // Moderate amplitudes keep full mixer gain clear of clipping
    set0 = '{16'sd1000, -16'sd300};
    set1 = '{16'sd200, 16'sd700};
    repeat (5) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    rd(OFS_MODE);
    cmp32("mode", MODE_RESET, v);
    rd(OFS_GAIN0);
    cmp32("gain", {10'h0, GAIN_UNITY, GAIN_UNITY}, v);
    rd(8'h40);
    cmp32("unmapped", 32'h2, {30'h0, resp});
    // Eight of the sixteen coarse codes, with mixer gain off and on
    for (int g = 0; g < 2; g++) begin
      for (int k = 0; k < 8; k++) begin
        wr(OFS_MODE, {21'h0, 1'(g), 6'h0, codes[k]});
        repeat (8) @(posedge CLK);
        rec(12);
        if (k < 4) cmp32("mix power", set0.i * set0.i + set0.q * set0.q, h[0].i * h[0].i + h[0].q * h[0].q);
        for (int j = 1; j < 12; j++) begin
          if (k < 4 || j >= 8) begin
            p = (k < 4) ? rot(codes[k], h[j-1]) : h[j-8];
            cmp16("mix i", p.i, h[j].i);
            cmp16("mix q", p.q, h[j].q);
          end
        end
        cmp16("pair1", set1.i, dout1.i);
      end
    end
    // Gain before offset, offsets sign extended, saturation
    wr(OFS_MODE, MODE_RESET);
    wr(OFS_GAIN0, 32'h00200200);
    wr(OFS_DCOF0, 32'h5);
    wr(OFS_DCOF1, 32'h1000);
    repeat (8) @(posedge CLK);
    cmp16("ofs i", 16'd505, dout0.i);
    cmp16("ofs q", -16'sd4396, dout0.q);
    wr(OFS_DCOF0, 32'h1ffb);
    repeat (8) @(posedge CLK);
    cmp16("neg ofs", 16'd495, dout0.i);
    wr(OFS_GAIN0, 32'h002007ff);
    set0 <= '{16'sd32000, -16'sd300};
    repeat (8) @(posedge CLK);
    cmp16("sat", 16'h7fff, dout0.i);
    // Phase constant of -0.25 folds Q into I
    set0 <= '{16'sd1000, -16'sd300};
    wr(OFS_GAIN0, 32'h00200400);
    wr(OFS_DCOF0, 32'h0);
    wr(OFS_DCOF1, 32'h0);
    wr(OFS_IQPH, 32'h00000c00);
    repeat (8) @(posedge CLK);
    cmp16("iq phase", 16'd1075, dout0.i);
    // One extra sample of delay on channel 0 only
    wr(OFS_IQPH, 32'h0);
    wr(OFS_DELAY, 32'h1);
    repeat (8) @(posedge CLK);
    cmp32("trim", 32'h1, trim);
    set0 <= '{16'sd2000, 16'sd400};
    for (int n = 0; n < 12 && dout0.q !== 16'd400; n++) @(posedge CLK);
    cmp16("trim old", 16'd1000, dout0.i);
    @(posedge CLK);
    cmp16("trim new", 16'd2000, dout0.i);
    // Oscillator at a quarter turn per clock, sync from source line 0
    wr(OFS_DELAY, 32'h0);
    wr(OFS_FREQ0, 32'h40000000);
    wr(OFS_MODE, 32'h00001500);
    pulse;
    rec(12);
    p = h[1];
    for (int j = 4; j < 12; j++) cmp16("period", h[j-4].i, h[j].i);
    pulse;
    rec(2);
    cmp16("resync", p.i, h[1].i);
    wr(OFS_PHASE, 32'h00004000);
    pulse;
    rec(1);
    cmp16("phase ofs", p.i, h[0].i);
    cmp16("pair1 fine", set1.q, dout1.q);
    tally_and_finish;
  end
endmodule
